// file: epcs_pkg.sv
// ****************************************
// shared constants for the register space
// ****************************************
package epcs_pkg;

  // bus shape
  localparam int unsigned DATA_W = 32;
  localparam int unsigned NUM_CNT = 4;

  // page bases
  localparam logic [31:0] CFG_BASE = 32'h0000_0000;
  localparam logic [31:0] STAT_BASE = 32'h0000_0400;
  localparam logic [31:0] CNT_BASE = 32'h0000_0500;

  // register offsets
  localparam logic [31:0] GT_RESET_OFF = CFG_BASE + 32'h0000_0000;
  localparam logic [31:0] RESET_OFF = CFG_BASE + 32'h0000_0004;
  localparam logic [31:0] MODE_OFF = CFG_BASE + 32'h0000_0008;
  localparam logic [31:0] TICK_OFF = CFG_BASE + 32'h0000_0020;
  localparam logic [31:0] USER_OFF = CFG_BASE + 32'h0000_0138;
  localparam logic [31:0] TX_STAT_OFF = STAT_BASE + 32'h0000_0000;
  localparam logic [31:0] RX_STAT_OFF = STAT_BASE + 32'h0000_0004;

  // field positions and reset values
  localparam int unsigned MODE_SNAP_SEL_BIT = 30;
  localparam logic [31:0] GT_RESET_RST = 32'h0000_0000;
  localparam logic [31:0] RESET_RST = 32'h0000_0000;
  localparam logic [31:0] MODE_RST = 32'h0000_0000;
  localparam logic [31:0] USER_RST = 32'h0000_0000;
  localparam logic [31:0] STAT_RST = 32'h0000_0000;

  // response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // decoded register targets, one-hot
  typedef enum logic [8:0] {
    REG_NONE = 9'h001,
    REG_GT_RESET = 9'h002,
    REG_RESET = 9'h004,
    REG_MODE = 9'h008,
    REG_TICK = 9'h010,
    REG_USER = 9'h020,
    REG_TX_STAT = 9'h040,
    REG_RX_STAT = 9'h080,
    REG_CNT = 9'h100
  } epcs_reg_t;

  // read answer: data plus response code
  typedef struct packed {
    logic [31:0] data;
    logic [1:0] resp;
  } epcs_rsp_t;

  // status event pulses from the core
  typedef struct packed {
    logic [31:0] tx;
    logic [31:0] rx;
  } epcs_evt_t;

endpackage : epcs_pkg

// file: epcs_stat_bank.sv
`timescale 1ns/1ns
// ****************************************
// live counters and snapshot capture
// ****************************************
module epcs_stat_bank
  import epcs_pkg::*;
#(
  parameter int unsigned N = NUM_CNT,
  parameter int unsigned W = DATA_W
)
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [N-1:0] inc,
  input wire logic snap_req,
  output logic snap_ack,
  output logic [N*W-1:0] cap
);

  logic take;

  // a toggle on the request not yet answered
  assign take = snap_req != snap_ack;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      snap_ack <= 1'b0;
    else if (take)
      snap_ack <= snap_req;
  end

  genvar gi;
  generate
    for (gi = 0; gi < N; gi++)
    begin : g_cnt
      logic [W-1:0] live_q;
      logic [W-1:0] cap_q;
      always_ff @(posedge clock or negedge rst_n)
      begin
        if (!rst_n)
        begin
          live_q <= '0;
          cap_q <= '0;
        end
        else if (take)
        begin
          // this cycle's event goes into the captured value, not lost
          cap_q <= live_q + W'(inc[gi]);
          live_q <= '0;
        end
        else
        begin
          live_q <= live_q + W'(inc[gi]);
        end
      end
      // one driver per slice of the flat capture bus
      assign cap[gi*W +: W] = cap_q;
    end
  endgenerate

endmodule : epcs_stat_bank

// file: epcs_axi_regs.sv
`timescale 1ns/1ns
// Functional notes
// - registers reachable over AXI4-Lite slave port
// - PCS RX and TX: three clock domains each
// - each RX lane runs on own recovered clock
// - lane data synchronized into RX core domain
// - lane clock is bit rate over serdes width
// - reset forces every register to default
// - pages: config 0x0000, status 0x0400, counters 0x0500
// - registers 32 bits, word aligned
// - full word written, strobes ignored, full read
// - unmapped addresses reserved, answer with error
// - select bit 0: pin pulse triggers snapshot
// - select bit 1: tick register access triggers
// - snapshot copies counters and clears live ones
// - captured values survive repeated reads
// - status read-only, clear on read, reset clears
module epcs_axi_regs
  import epcs_pkg::*;
#(
  parameter int unsigned N_CNT = NUM_CNT
)
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic stats_snapshot_pulse_in,
  input wire logic [N_CNT-1:0] stat_inc,
  input wire epcs_evt_t status_evt,
  input wire logic rx_reset,
  input wire logic tx_reset,
  output logic [31:0] ctl_gt_reset,
  output logic [31:0] ctl_reset,
  output logic [31:0] ctl_mode,
  output logic [31:0] ctl_user
);

  // ****************************************
  // address decode
  // ****************************************

  function automatic epcs_reg_t reg_decode(input logic [31:0] a);
    epcs_reg_t r;
    r = REG_NONE;
    if (a[1:0] == 2'h0)
    begin
      case (a)
        GT_RESET_OFF: r = REG_GT_RESET;
        RESET_OFF: r = REG_RESET;
        MODE_OFF: r = REG_MODE;
        TICK_OFF: r = REG_TICK;
        USER_OFF: r = REG_USER;
        TX_STAT_OFF: r = REG_TX_STAT;
        RX_STAT_OFF: r = REG_RX_STAT;
        default:
          if (a >= CNT_BASE && a < CNT_BASE + 32'(N_CNT * 4))
            r = REG_CNT;
      endcase
    end
    return r;
  endfunction : reg_decode

  logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;
  logic wr_hs, rd_hs;
  epcs_reg_t wdec, rdec;
  logic [31:0] tx_stat_q, rx_stat_q;
  logic [31:0] tx_clr, rx_clr;
  logic snap_meta_q, snap_sync_q, snap_prev_q;
  logic snap_req_q, snap_ack, tick_hit, pin_rise, trigger;
  logic [N_CNT*DATA_W-1:0] cap;
  logic [5:0] cnt_idx;
  epcs_rsp_t rd_rsp;

  assign wdec = reg_decode(s_axi_awaddr);
  assign rdec = reg_decode(s_axi_araddr);
  assign wr_hs = awready_q & s_axi_awvalid & s_axi_wvalid;
  assign rd_hs = arready_q & s_axi_arvalid;

  // ****************************************
  // write channel
  // ****************************************

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      awready_q <= 1'b0;
      wready_q <= 1'b0;
    end
    else
    begin
      awready_q <= !awready_q && s_axi_awvalid && s_axi_wvalid && !bvalid_q;
      wready_q <= !awready_q && s_axi_awvalid && s_axi_wvalid && !bvalid_q;
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end
    else if (wr_hs)
    begin
      bvalid_q <= 1'b1;
      bresp_q <= (wdec == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
    end
    else if (s_axi_bready)
      bvalid_q <= 1'b0;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctl_gt_reset <= GT_RESET_RST;
      ctl_reset <= RESET_RST;
      ctl_mode <= MODE_RST;
      ctl_user <= USER_RST;
    end
    else if (wr_hs)
    begin
      case (wdec)
        REG_GT_RESET: ctl_gt_reset <= s_axi_wdata;
        REG_RESET: ctl_reset <= s_axi_wdata;
        REG_MODE: ctl_mode <= s_axi_wdata;
        REG_USER: ctl_user <= s_axi_wdata;
        default: ;
      endcase
    end
  end

  // ****************************************
  // status registers
  // ****************************************

  // clear on read or direction reset
  assign tx_clr = (rd_hs && rdec == REG_TX_STAT) || tx_reset ? 32'hffff_ffff : 32'h0;
  assign rx_clr = (rd_hs && rdec == REG_RX_STAT) || rx_reset ? 32'hffff_ffff : 32'h0;

  // tx and rx apart
  // sticky events, a new event beats the clear
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_stat_q <= STAT_RST;
      rx_stat_q <= STAT_RST;
    end
    else
    begin
      tx_stat_q <= (tx_stat_q & ~tx_clr) | status_evt.tx;
      rx_stat_q <= (rx_stat_q & ~rx_clr) | status_evt.rx;
    end
  end

  // ****************************************
  // snapshot trigger
  // ****************************************

  // source clock set outside
  // pin pulse through two flops, then edge detect
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      snap_meta_q <= 1'b0;
      snap_sync_q <= 1'b0;
      snap_prev_q <= 1'b0;
    end
    else
    begin
      snap_meta_q <= stats_snapshot_pulse_in;
      snap_sync_q <= snap_meta_q;
      snap_prev_q <= snap_sync_q;
    end
  end

  assign pin_rise = snap_sync_q & ~snap_prev_q;
  assign tick_hit = (wr_hs && wdec == REG_TICK) || (rd_hs && rdec == REG_TICK);
  assign trigger = ctl_mode[MODE_SNAP_SEL_BIT] ? tick_hit : pin_rise;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      snap_req_q <= 1'b0;
    else if (trigger && snap_req_q == snap_ack)
      snap_req_q <= ~snap_req_q;
  end

  epcs_stat_bank #(
    .N(N_CNT),
    .W(DATA_W)
  ) u_bank (
    .clock(clock),
    .rst_n(rst_n),
    .inc(stat_inc),
    .snap_req(snap_req_q),
    .snap_ack(snap_ack),
    .cap(cap)
  );

  // ****************************************
  // read channel
  // ****************************************

  assign cnt_idx = 6'((s_axi_araddr - CNT_BASE) >> 2);

  // counter reads have no side effect
  always_comb
  begin
    rd_rsp.data = 32'h0;
    rd_rsp.resp = RESP_OKAY;
    case (rdec)
      REG_GT_RESET: rd_rsp.data = ctl_gt_reset;
      REG_RESET: rd_rsp.data = ctl_reset;
      REG_MODE: rd_rsp.data = ctl_mode;
      REG_USER: rd_rsp.data = ctl_user;
      REG_TX_STAT: rd_rsp.data = tx_stat_q;
      REG_RX_STAT: rd_rsp.data = rx_stat_q;
      REG_CNT: rd_rsp.data = cap[cnt_idx*DATA_W +: DATA_W];
      REG_TICK: rd_rsp.data = 32'h0;
      default: rd_rsp.resp = RESP_SLVERR;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      arready_q <= 1'b0;
    else
      arready_q <= !arready_q && s_axi_arvalid && !rvalid_q;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0;
      rresp_q <= RESP_OKAY;
    end
    else if (rd_hs)
    begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_rsp.data;
      rresp_q <= rd_rsp.resp;
    end
    else if (s_axi_rready)
      rvalid_q <= 1'b0;
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // ****************************************
  // assertions
  // ****************************************

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  property p_bresp_err;
    wr_hs && wdec == REG_NONE |=> s_axi_bvalid && s_axi_bresp == RESP_SLVERR;
  endproperty
  a_bresp_err: assert property (p_bresp_err) else $error("unmapped write not refused");

  property p_rd_answer;
    rd_hs |=> s_axi_rvalid;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read not answered");

  property p_misaligned;
    rd_hs && s_axi_araddr[1:0] != 2'h0 |=> s_axi_rresp == RESP_SLVERR;
  endproperty
  a_misaligned: assert property (p_misaligned) else $error("misaligned read ok");

  property p_full_word;
    wr_hs && wdec == REG_MODE |=> ctl_mode == $past(s_axi_wdata);
  endproperty
  a_full_word: assert property (p_full_word) else $error("mode word not fully written");

  property p_pin_trig;
    pin_rise && !ctl_mode[MODE_SNAP_SEL_BIT] && snap_req_q == snap_ack |=> $changed(snap_req_q);
  endproperty
  a_pin_trig: assert property (p_pin_trig) else $error("pin pulse missed");

  property p_tick_only;
    ctl_mode[MODE_SNAP_SEL_BIT] && !tick_hit |=> $stable(snap_req_q);
  endproperty
  a_tick_only: assert property (p_tick_only) else $error("snapshot without tick");

  property p_handshake;
    $changed(snap_req_q) |-> ##[1:2] snap_ack == snap_req_q;
  endproperty
  a_handshake: assert property (p_handshake) else $error("snapshot not acknowledged");

  property p_cap_held;
    !$changed(snap_ack) |-> $stable(cap);
  endproperty
  a_cap_held: assert property (p_cap_held) else $error("capture changed between snapshots");

  property p_rx_clear;
    rx_reset && status_evt.rx == 32'h0 |=> rx_stat_q == 32'h0;
  endproperty
  a_rx_clear: assert property (p_rx_clear) else $error("rx status not cleared");

  c_cnt_read: cover property (rd_hs && rdec == REG_CNT);
  c_tick_snap: cover property (tick_hit && ctl_mode[MODE_SNAP_SEL_BIT] ##[1:2] $changed(snap_ack));
  c_pin_snap: cover property (pin_rise && !ctl_mode[MODE_SNAP_SEL_BIT]);
  c_err_write: cover property (wr_hs && wdec == REG_NONE);

endmodule : epcs_axi_regs

// file: epcs_axi_master.sv
`timescale 1ns/1ns
// ****************************************
// register bus master model
// ****************************************
module epcs_axi_master
  import epcs_pkg::*;
(
  input wire logic clock,
  output logic [31:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  output logic [31:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  int stall = 0;

  // idle bus from time zero
  initial
  begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_wvalid, s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
  end

  // one word write, single strobe lane on purpose
  // strobes partial
  task wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] resp);
    @(negedge clock);
    s_axi_awaddr = a;
    s_axi_wdata = d;
    s_axi_wstrb = 4'h1;
    s_axi_awvalid = 1'b1;
    s_axi_wvalid = 1'b1;
    do @(negedge clock); while (s_axi_awready !== 1'b1 || s_axi_wready !== 1'b1);
    @(negedge clock);
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_awaddr = ~a; // released lines show inverse
    s_axi_wdata = ~d;
    repeat (stall) @(negedge clock);
    s_axi_bready = 1'b1;
    while (s_axi_bvalid !== 1'b1) @(negedge clock);
    resp = s_axi_bresp;
    @(negedge clock);
    s_axi_bready = 1'b0;
  endtask : wr

  // one word read
  task rd(input logic [31:0] a, output epcs_rsp_t r);
    @(negedge clock);
    s_axi_araddr = a;
    s_axi_arvalid = 1'b1;
    do @(negedge clock); while (s_axi_arready !== 1'b1);
    @(negedge clock);
    s_axi_arvalid = 1'b0;
    s_axi_araddr = ~a;
    repeat (stall) @(negedge clock);
    s_axi_rready = 1'b1;
    while (s_axi_rvalid !== 1'b1) @(negedge clock);
    r.data = s_axi_rdata;
    r.resp = s_axi_rresp;
    @(negedge clock);
    s_axi_rready = 1'b0;
  endtask : rd
endmodule : epcs_axi_master

// file: ethernet_pcs_axi_register_space_tb.sv
`timescale 1ns/1ns
// ****************************************
// bench top
// ****************************************
module ethernet_pcs_axi_register_space_tb
  import epcs_pkg::*;
;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic stats_snapshot_pulse_in = 1'b0;
  logic [3:0] stat_inc = '0;
  epcs_evt_t status_evt = '0;
  logic rx_reset = 1'b0;
  logic tx_reset = 1'b0;
  logic [31:0] ctl_gt_reset, ctl_reset, ctl_mode, ctl_user;
  int num_errors = 0;
  int checks_done = 0;

  always #5 clock = ~clock;

  epcs_axi_regs dut_u (
    .clock(clock),
    .rst_n(rst_n),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .stats_snapshot_pulse_in(stats_snapshot_pulse_in),
    .stat_inc(stat_inc),
    .status_evt(status_evt),
    .rx_reset(rx_reset),
    .tx_reset(tx_reset),
    .ctl_gt_reset(ctl_gt_reset),
    .ctl_reset(ctl_reset),
    .ctl_mode(ctl_mode),
    .ctl_user(ctl_user)
  );

  epcs_axi_master m_u (
    .clock(clock),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready)
  );

  // ****************************************
  // helpers
  // ****************************************
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task wrc(input logic [31:0] a, input logic [31:0] d, input logic [1:0] e);
    logic [1:0] r;
    m_u.wr(a, d, r);
    chk(32'(r), 32'(e));
  endtask : wrc

  task rdc(input logic [31:0] a, input logic [31:0] e, input logic [1:0] er);
    epcs_rsp_t x;
    m_u.rd(a, x);
    chk(32'(x.resp), 32'(er));
    if (er == RESP_OKAY)
      chk(x.data, e);
  endtask : rdc

  task bump(input int i, input int n);
    repeat (n)
    begin
      @(negedge clock);
      stat_inc[i] = 1'b1;
    end
    @(negedge clock);
    stat_inc = '0;
  endtask : bump

  task pulse;
    @(negedge clock);
    stats_snapshot_pulse_in = 1'b1;
    repeat (2) @(negedge clock);
    stats_snapshot_pulse_in = 1'b0;
    repeat (8) @(negedge clock);
  endtask : pulse

  // ****************************************
  // scenarios
  // ****************************************
  task t_reset;
    rdc(GT_RESET_OFF, GT_RESET_RST, RESP_OKAY);
    rdc(RESET_OFF, RESET_RST, RESP_OKAY);
    rdc(MODE_OFF, MODE_RST, RESP_OKAY);
    rdc(USER_OFF, USER_RST, RESP_OKAY);
    rdc(RX_STAT_OFF, STAT_RST, RESP_OKAY);
  endtask : t_reset

  task t_bus;
    wrc(USER_OFF, 32'ha5c3_0f96, RESP_OKAY);
    rdc(USER_OFF, 32'ha5c3_0f96, RESP_OKAY);
    chk(ctl_user, 32'ha5c3_0f96);
    wrc(GT_RESET_OFF, 32'h0000_0011, RESP_OKAY);
    chk(ctl_gt_reset, 32'h0000_0011);
    wrc(RESET_OFF, 32'hc000_0003, RESP_OKAY);
    rdc(RESET_OFF, 32'hc000_0003, RESP_OKAY);
    chk(ctl_reset, 32'hc000_0003);
    wrc(USER_OFF + 32'h1, 32'h0, RESP_SLVERR);
    rdc(USER_OFF + 32'h2, 32'h0, RESP_SLVERR);
    rdc(USER_OFF, 32'ha5c3_0f96, RESP_OKAY);
    rdc(32'h0000_0200, 32'h0, RESP_SLVERR);
    rdc(STAT_BASE + 32'h8, 32'h0, RESP_SLVERR);
    rdc(CNT_BASE + 32'h10, 32'h0, RESP_SLVERR);
  endtask : t_bus

  task t_pin;
    for (int i = 0; i < 4; i++)
      bump(i, i + 1);
    pulse();
    for (int i = 0; i < 4; i++)
    begin
      rdc(CNT_BASE + 32'(4 * i), 32'(i + 1), RESP_OKAY);
      rdc(CNT_BASE + 32'(4 * i), 32'(i + 1), RESP_OKAY);
    end
    bump(0, 2);
    rdc(CNT_BASE, 32'h1, RESP_OKAY);
    pulse();
    rdc(CNT_BASE, 32'h2, RESP_OKAY);
    rdc(CNT_BASE + 32'h4, 32'h0, RESP_OKAY);
  endtask : t_pin

  task t_tick;
    wrc(MODE_OFF, 32'h4000_0000, RESP_OKAY);
    chk(32'(ctl_mode[MODE_SNAP_SEL_BIT]), 32'h1);
    bump(1, 3);
    pulse();
    rdc(CNT_BASE + 32'h4, 32'h0, RESP_OKAY);
    wrc(TICK_OFF, 32'h0, RESP_OKAY);
    rdc(CNT_BASE + 32'h4, 32'h3, RESP_OKAY);
    bump(1, 2);
    rdc(TICK_OFF, 32'h0, RESP_OKAY);
    rdc(CNT_BASE + 32'h4, 32'h2, RESP_OKAY);
  endtask : t_tick

  task t_status;
    m_u.stall = 3;
    @(negedge clock);
    status_evt = '{tx: 32'h5, rx: 32'h80};
    @(negedge clock);
    status_evt = '{tx: 32'h0, rx: 32'h0};
    rdc(TX_STAT_OFF, 32'h5, RESP_OKAY);
    rdc(TX_STAT_OFF, 32'h0, RESP_OKAY);
    wrc(RX_STAT_OFF, 32'hffff_ffff, RESP_OKAY);
    @(negedge clock);
    status_evt.tx = 32'h1;
    rx_reset = 1'b1;
    @(negedge clock);
    status_evt.tx = 32'h0;
    rx_reset = 1'b0;
    rdc(RX_STAT_OFF, 32'h0, RESP_OKAY);
    @(negedge clock);
    tx_reset = 1'b1;
    @(negedge clock);
    tx_reset = 1'b0;
    rdc(TX_STAT_OFF, 32'h0, RESP_OKAY);
    m_u.stall = 0;
  endtask : t_status

  task t_rerst;
    @(negedge clock);
    rst_n = 1'b0;
    repeat (2) @(negedge clock);
    rst_n = 1'b1;
    chk(ctl_mode, MODE_RST);
    rdc(USER_OFF, USER_RST, RESP_OKAY);
    rdc(CNT_BASE, 32'h0, RESP_OKAY);
  endtask : t_rerst

  task results;
    $display("checks=%0d errors=%0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : results

  // main sequence
  initial
  begin
    repeat (4) @(posedge clock);
    @(negedge clock);
    rst_n = 1'b1;
    t_reset();
    t_bus();
    t_pin();
    t_tick();
    t_status();
    t_rerst();
    results();
  end

  // watchdog
  initial
  begin
    #200000;
    num_errors++;
    results();
  end
endmodule : ethernet_pcs_axi_register_space_tb
